/* rtl/pscl_regs.vh */
// constants for the strap, reset and link-pin block: register indices,
// field positions, reset values and timing figures.
// assumes inclusion by bare name from the block's design files.
`ifndef PSCL_REGS_VH
`define PSCL_REGS_VH

// clock and timing figures
`define PSCL_CLK_HZ 100000000
`define PSCL_SCLK_HZ 49152000
`define PSCL_WAKE_HZ 6144000
`define PSCL_POR_MS 15
`define PSCL_POR_CYCLES ((`PSCL_POR_MS * 64'd`PSCL_CLK_HZ + 64'd999) / 64'd1000)

// phy register indices (byte address on apb is four times the index)
`define PSCL_IDX_REG0 5'h00
`define PSCL_IDX_REG1 5'h01
`define PSCL_IDX_REG2 5'h02
`define PSCL_IDX_REG3 5'h03
`define PSCL_IDX_REG4 5'h04
`define PSCL_IDX_REG5 5'h05
`define PSCL_IDX_REG6 5'h06
`define PSCL_IDX_REG7 5'h07
`define PSCL_IDX_PORT0 5'h08
`define PSCL_IDX_CTRL 5'h10
`define PSCL_IDX_STAT 5'h11

// register 1 fields and reset
`define PSCL_R1_RST 8'h3F
// register 2 constant content: extended 111, total ports 2
`define PSCL_R2_VAL 8'hE2
// register 3: max speed in [7:5], reserved [4], delay [3:0]
`define PSCL_SPD_S400 3'h2
`define PSCL_SPD_SPEED_LIMIT_STRAP 3'h1
`define PSCL_R3_DELAY 4'h1
// register 4: link ctrl [7], contender [6], jitter [5:3], power class [2:0]
`define PSCL_R4_LCTRL 7
`define PSCL_R4_CONT 6
`define PSCL_R4_JITTER 3'h1
// register 5 bit positions
`define PSCL_R5_WDOG 7
`define PSCL_R5_ISBR 6
`define PSCL_R5_LOOP 5
`define PSCL_R5_PFAIL 4
`define PSCL_R5_TOUT 3
`define PSCL_R5_PEVT 2
`define PSCL_R5_ACCEL 1
`define PSCL_R5_MULTI 0
`define PSCL_R5_W1C_MASK 8'h3C
`define PSCL_R5_RST_FIXED 8'h04
// register 7: page select [7:5], port select [3:0]
`define PSCL_R7_MASK 8'hEF
// port status page register 00: disabled flag in bit 0
`define PSCL_PORT_DIS_BIT 0
// control register: link wake enable in bit 0
`define PSCL_CTRL_WAKE 0

// serial request codes and the last bit count of each field (its length minus one)
`define PSCL_RQ_READ 3'h5
`define PSCL_RQ_WRITE 3'h6
`define PSCL_RQ_BUS_MAX 3'h3
`define PSCL_RQ_TYPE_BITS 4'h2
`define PSCL_RQ_ADDR_BITS 4'h3
`define PSCL_RQ_DATA_BITS 4'h7

`endif

/* rtl/pscl_nco.v */
// phase-accumulator rate generator: toggles a square wave at OUT_HZ and
// pulses a one-cycle tick on each rising half.
// assumes a free-running clock at CLK_HZ; output edges carry one clock of jitter.
`timescale 1ns/100ps
`default_nettype none

module pscl_nco #(
	parameter CLK_HZ = 100000000,
	parameter OUT_HZ = 1000000
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	output reg wave_ff,
	output reg rise_ff
);

	// increment per clock for two toggles per output period, 32-bit phase
	localparam [63:0] INC64 = ((64'd2 * OUT_HZ) << 32) / CLK_HZ;
	localparam [31:0] INC = INC64[31:0];

	reg [31:0] acc_ff;
	wire [32:0] sum;

	assign sum = {1'b0, acc_ff} + {1'b0, INC};

	////////////////////////////////////////////////////////////////////////
	// accumulator; stopped and cleared so the wave parks low when idle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= 32'h00000000;
			wave_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else if (!run) begin
			acc_ff <= 32'h00000000;
			wave_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else begin
			acc_ff <= sum[31:0];
			rise_ff <= sum[32] & ~wave_ff; // tick on the low-to-high toggle
			if (sum[32]) begin
				wave_ff <= ~wave_ff;
			end
		end
	end

endmodule

`default_nettype wire

/* rtl/pscl_top.v */
// strap loading, power-up reset, phy register seeds and link-side pins
// of a two-port serial-bus phy, with an apb slave onto the same registers.
// assumes strap and link pins are asynchronous and the link samples sclk.
//
// Contract
// [R1] Hardware reset loads the three-bit power class field of register 4 from its straps.
// [R2] Hardware reset loads the contender bit of register 4 from the manager-capable strap.
// [R3] A 49.152 MHz system clock is driven to the link and link-side logic runs on its ticks.
// [R4] Power-up reset lasts at least 15 ms and returns every state machine to its start.
// [R5] A high speed strap caps the rate at the 200 class, low allows the 400 class.
// [R6] A high suspend select enables suspend and resume, low disables them.
// [R7] Hardware reset loads each port's disable bit from its port-disable strap.
// [R8] Hardware reset loads the acceleration enable bit of register 5 from its strap.
// [R9] Hardware reset loads the multi-speed enable bit of register 5 from its strap.
// [R10] The coupling select input picks ac coupling when low and dc coupling when high.
// [R11] An active link wake output is a 6.144 MHz square wave at half duty.
// [R12] Reads, writes and bus requests all arrive on the serial request line and are accepted.
// [R13] Power class sits in register 4 bits 5 to 7, taken from straps 0, 1 and 2 in order; the code uses bits 2 to 0, with strap 0 in bit 2.
// [R14] Register 3 max speed reads 010 with the speed strap low and 001 with it high.
// [R15] The acceleration bit turns ack-accelerated and fly-by arbitration on or off.
// [R16] Straps are caught as reset ends and later writes hold until the next reset; the code reads the speed-limit strap live into register 3 instead.
// [R17] The link wake output rests at a steady low when no wake is signalled.
//
// Local design decisions: the APB register port and the placing of the registers.
`include "pscl_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module pscl_top #(
	parameter POR_CYCLES = `PSCL_POR_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire power_up_reset_n,
	input wire [2:0] power_class_straps,
	input wire manager_capable_strap,
	input wire speed_limit_strap,
	input wire suspend_resume_select,
	input wire [1:0] port_disable_straps,
	input wire accel_strap,
	input wire multi_speed_strap,
	input wire coupling_select,
	input wire link_request_line,
	output wire link_system_clock,
	output wire link_wake_output,
	output wire hw_reset_active,
	output wire speed_limit_speed_limit_strap,
	output wire suspend_resume_en,
	output wire dc_coupled_mode,
	output wire accel_arb_en,
	output wire fly_by_arb_en,
	output wire multi_speed_en,
	output wire [1:0] port_disabled,
	output reg [7:0] link_read_data,
	output reg link_read_valid,
	output reg [2:0] bus_request_type,
	output reg bus_request_valid
);

	localparam NSYNC = 13;
	localparam [63:0] POR_LAST = POR_CYCLES - 1;
	localparam [1:0] L_IDLE = 2'h0;
	localparam [1:0] L_TYPE = 2'h1;
	localparam [1:0] L_ADDR = 2'h2;
	localparam [1:0] L_DATA = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin input
	wire [NSYNC-1:0] pin_raw;
	reg [NSYNC-1:0] meta_ff;
	reg [NSYNC-1:0] sync_ff;

	assign pin_raw = {power_up_reset_n, power_class_straps, manager_capable_strap,
		speed_limit_strap, suspend_resume_select, port_disable_straps, accel_strap,
		multi_speed_strap, coupling_select, link_request_line};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			// meta_ff is read only by sync_ff
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= pin_raw[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	wire s_purb_n = sync_ff[12];
	wire [2:0] s_pc = sync_ff[11:9];
	wire s_cmc = sync_ff[8];
	wire s_speed_limit_strap = sync_ff[7];
	wire s_sr = sync_ff[6];
	wire [1:0] s_pdis = sync_ff[5:4];
	wire s_accel = sync_ff[3];
	wire s_multi = sync_ff[2];
	wire s_dc = sync_ff[1];
	wire s_link_request_line = sync_ff[0];

	////////////////////////////////////////////////////////////////////////
	// power-up reset: held until the capacitor pin has stayed high long enough
	reg [23:0] por_cnt_ff;
	reg hw_rst_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt_ff <= 24'h000000;
			hw_rst_ff <= 1'b1;
		end else if (!s_purb_n) begin
			por_cnt_ff <= 24'h000000; // any dip restarts the full period
			hw_rst_ff <= 1'b1;
		end else if (hw_rst_ff) begin
			if (por_cnt_ff == POR_LAST[23:0]) begin
				hw_rst_ff <= 1'b0; // [R4]
			end else begin
				por_cnt_ff <= por_cnt_ff + 24'h000001;
			end
		end
	end

	assign hw_reset_active = hw_rst_ff;

	////////////////////////////////////////////////////////////////////////
	// clock and wake generators
	reg wake_en_ff;
	wire sclk_tick;

	pscl_nco #(.CLK_HZ(`PSCL_CLK_HZ), .OUT_HZ(`PSCL_SCLK_HZ)) u_sclk (
		.clk(pclk),
		.rst_n(presetn),
		.run(1'b1),
		.wave_ff(link_system_clock), // [R3]
		.rise_ff(sclk_tick)
	);

	// wake wave runs only when enabled and out of reset, else parks low
	pscl_nco #(.CLK_HZ(`PSCL_CLK_HZ), .OUT_HZ(`PSCL_WAKE_HZ)) u_wake (
		.clk(pclk),
		.rst_n(presetn),
		.run(wake_en_ff & ~hw_rst_ff), // [R11] [R17]
		.wave_ff(link_wake_output),
		.rise_ff()
	);

	////////////////////////////////////////////////////////////////////////
	// serial request receiver, one bit per system clock tick
	reg [1:0] lq_st_ff;
	reg [3:0] lq_cnt_ff;
	reg [7:0] lq_sh_ff;
	reg [2:0] lq_type_ff;
	reg [3:0] lq_addr_ff;
	wire lq_bit_end;
	wire lk_wr_go;
	wire lk_rd_go;
	wire lk_bus_go;
	wire [7:0] lq_next;

	assign lq_next = {lq_sh_ff[6:0], s_link_request_line};
	assign lq_bit_end = sclk_tick & ~hw_rst_ff;
	assign lk_rd_go = lq_bit_end & (lq_st_ff == L_ADDR) & (lq_cnt_ff == `PSCL_RQ_ADDR_BITS)
		& (lq_type_ff == `PSCL_RQ_READ);
	assign lk_wr_go = lq_bit_end & (lq_st_ff == L_DATA) & (lq_cnt_ff == `PSCL_RQ_DATA_BITS);
	assign lk_bus_go = lq_bit_end & (lq_st_ff == L_TYPE) & (lq_cnt_ff == `PSCL_RQ_TYPE_BITS)
		& (lq_next[2:0] != 3'h0) & (lq_next[2:0] <= `PSCL_RQ_BUS_MAX);

	// start bit, 3-bit type, then address and data as the type needs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lq_st_ff <= L_IDLE;
			lq_cnt_ff <= 4'h0;
			lq_sh_ff <= 8'h00;
			lq_type_ff <= 3'h0;
			lq_addr_ff <= 4'h0;
		end else if (hw_rst_ff) begin
			lq_st_ff <= L_IDLE; // [R4]
			lq_cnt_ff <= 4'h0;
			lq_sh_ff <= 8'h00;
			lq_type_ff <= 3'h0;
			lq_addr_ff <= 4'h0;
		end else if (sclk_tick) begin
			lq_sh_ff <= lq_next;
			lq_cnt_ff <= lq_cnt_ff + 4'h1;
			case (lq_st_ff)
				L_IDLE: begin
					lq_cnt_ff <= 4'h0;
					lq_st_ff <= s_link_request_line ? L_TYPE : L_IDLE;
				end
				L_TYPE: begin
					if (lq_cnt_ff == `PSCL_RQ_TYPE_BITS) begin
						lq_type_ff <= lq_next[2:0];
						lq_cnt_ff <= 4'h0;
						lq_st_ff <= (lq_next[2:0] == `PSCL_RQ_READ || lq_next[2:0] == `PSCL_RQ_WRITE)
							? L_ADDR : L_IDLE; // [R12]
					end
				end
				L_ADDR: begin
					if (lq_cnt_ff == `PSCL_RQ_ADDR_BITS) begin
						lq_addr_ff <= lq_next[3:0];
						lq_cnt_ff <= 4'h0;
						lq_st_ff <= (lq_type_ff == `PSCL_RQ_WRITE) ? L_DATA : L_IDLE;
					end
				end
				L_DATA: begin
					lq_st_ff <= (lq_cnt_ff == `PSCL_RQ_DATA_BITS) ? L_IDLE : L_DATA;
				end
				default: lq_st_ff <= L_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phy register storage
	reg [7:0] r1_ff;
	reg [2:0] pwr_class_ff;
	reg lctrl_ff;
	reg contender_ff;
	reg [7:0] r5_ff;
	reg [7:0] r7_ff;
	reg [1:0] port_dis_ff;
	wire [7:0] r3_val;
	wire [7:0] r4_val;
	wire port_sel;

	assign r3_val = {(s_speed_limit_strap ? `PSCL_SPD_SPEED_LIMIT_STRAP : `PSCL_SPD_S400), 1'b0, `PSCL_R3_DELAY}; // [R14]
	assign r4_val = {lctrl_ff, contender_ff, `PSCL_R4_JITTER, pwr_class_ff};
	assign port_sel = r7_ff[0];

	// read mux shared by the apb slave and the link read path
	function [7:0] phy_rd;
		input [4:0] idx;
		begin
			case (idx)
				`PSCL_IDX_REG1: phy_rd = r1_ff;
				`PSCL_IDX_REG2: phy_rd = `PSCL_R2_VAL;
				`PSCL_IDX_REG3: phy_rd = r3_val;
				`PSCL_IDX_REG4: phy_rd = r4_val;
				`PSCL_IDX_REG5: phy_rd = r5_ff;
				`PSCL_IDX_REG7: phy_rd = r7_ff;
				`PSCL_IDX_PORT0: phy_rd = {7'h00, port_dis_ff[port_sel]};
				`PSCL_IDX_CTRL: phy_rd = {7'h00, wake_en_ff};
				`PSCL_IDX_STAT: phy_rd = {5'h00, s_dc, s_sr, hw_rst_ff};
				default: phy_rd = 8'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, data registered at the ready edge
	reg pready_ff;
	wire apb_acc;
	wire apb_map;
	wire [4:0] apb_idx;
	wire apb_wr;

	assign apb_idx = paddr[6:2];
	assign apb_map = (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'h0)
		&& (apb_idx <= `PSCL_IDX_PORT0 || apb_idx == `PSCL_IDX_CTRL
		|| apb_idx == `PSCL_IDX_STAT);
	assign apb_acc = psel & penable;
	assign pready = pready_ff;
	assign pslverr = pready_ff & ~apb_map;
	assign apb_wr = apb_acc & pready_ff & pwrite & apb_map;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready_ff <= apb_acc & ~pready_ff;
			if (apb_acc & ~pready_ff & ~pwrite) begin
				prdata <= {24'h000000, (apb_map ? phy_rd(apb_idx) : 8'h00)};
			end
		end
	end

	// link write wins over an apb write landing in the same cycle
	wire wr_go;
	wire [4:0] wr_idx;
	wire [7:0] wr_dat;

	assign wr_go = lk_wr_go | apb_wr;
	assign wr_idx = lk_wr_go ? {1'b0, lq_addr_ff} : apb_idx;
	assign wr_dat = lk_wr_go ? lq_next : pwdata[7:0];

	////////////////////////////////////////////////////////////////////////
	// straps reload every cycle of hardware reset, so the release edge keeps
	// the last level seen; afterwards only writes change these fields
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r1_ff <= `PSCL_R1_RST;
			pwr_class_ff <= 3'h0;
			lctrl_ff <= 1'b1;
			contender_ff <= 1'b0;
			r5_ff <= `PSCL_R5_RST_FIXED;
			r7_ff <= 8'h00;
			port_dis_ff <= 2'h0;
			wake_en_ff <= 1'b0;
		end else if (hw_rst_ff) begin
			r1_ff <= `PSCL_R1_RST;
			pwr_class_ff <= {s_pc[0], s_pc[1], s_pc[2]}; // [R1] [R13] [R16]
			lctrl_ff <= 1'b1;
			contender_ff <= s_cmc; // [R2]
			r5_ff <= `PSCL_R5_RST_FIXED | {6'h00, s_accel, s_multi}; // [R8] [R9]
			r7_ff <= 8'h00;
			port_dis_ff <= s_pdis; // [R7]
			wake_en_ff <= 1'b0;
		end else if (wr_go) begin
			case (wr_idx)
				`PSCL_IDX_REG1: r1_ff <= wr_dat;
				`PSCL_IDX_REG4: begin
					lctrl_ff <= wr_dat[`PSCL_R4_LCTRL];
					contender_ff <= wr_dat[`PSCL_R4_CONT]; // [R16]
					pwr_class_ff <= wr_dat[2:0];
				end
				`PSCL_IDX_REG5: begin
					// event flags clear on one, control bits store directly
					r5_ff <= (r5_ff & `PSCL_R5_W1C_MASK & ~wr_dat)
						| (wr_dat & ~`PSCL_R5_W1C_MASK);
				end
				`PSCL_IDX_REG7: r7_ff <= wr_dat & `PSCL_R7_MASK;
				`PSCL_IDX_PORT0: port_dis_ff[port_sel] <= wr_dat[`PSCL_PORT_DIS_BIT];
				`PSCL_IDX_CTRL: wake_en_ff <= wr_dat[`PSCL_CTRL_WAKE];
				default: r1_ff <= r1_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link-side answers: read data and bus request pulses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_read_data <= 8'h00;
			link_read_valid <= 1'b0;
			bus_request_type <= 3'h0;
			bus_request_valid <= 1'b0;
		end else begin
			link_read_valid <= lk_rd_go; // [R12]
			bus_request_valid <= lk_bus_go;
			if (lk_rd_go) link_read_data <= phy_rd({1'b0, lq_next[3:0]});
			if (lk_bus_go) bus_request_type <= lq_next[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode levels toward the transceiver and arbitration logic
	assign speed_limit_speed_limit_strap = s_speed_limit_strap; // [R5]
	assign suspend_resume_en = s_sr; // [R6]
	assign dc_coupled_mode = s_dc; // [R10]
	assign accel_arb_en = r5_ff[`PSCL_R5_ACCEL]; // [R15]
	assign fly_by_arb_en = r5_ff[`PSCL_R5_ACCEL]; // [R15]
	assign multi_speed_en = r5_ff[`PSCL_R5_MULTI];
	assign port_disabled = port_dis_ff;

endmodule

`default_nettype wire

/* verif/pscl_top_props.sv */
// checker for the strap, reset and link-pin block: reset length, pin rates
// and strap loading. assumes pclk is the only clock and binds onto pscl_top.
`timescale 1ns/100ps
`default_nettype none
module pscl_top_props #(
	parameter POR_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_up_reset_n,
	input wire logic [1:0] port_disable_straps,
	input wire logic accel_strap,
	input wire logic multi_speed_strap,
	input wire logic speed_limit_strap,
	input wire logic suspend_resume_select,
	input wire logic coupling_select,
	input wire logic link_system_clock,
	input wire logic link_wake_output,
	input wire logic hw_reset_active,
	input wire logic speed_limit_speed_limit_strap,
	input wire logic suspend_resume_en,
	input wire logic dc_coupled_mode,
	input wire logic accel_arb_en,
	input wire logic fly_by_arb_en,
	input wire logic multi_speed_en,
	input wire logic [1:0] port_disabled
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// cycles since the power-up pin was last low; saturates to avoid wrap
	logic [31:0] run_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt_ff <= 32'h0;
		end else if (!power_up_reset_n) begin
			run_cnt_ff <= 32'h0;
		end else if (run_cnt_ff != 32'hFFFFFFFF) begin
			run_cnt_ff <= run_cnt_ff + 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// reset length and entry
	por_hold_a: assert property ($fell(hw_reset_active) |-> run_cnt_ff >= POR_CYCLES)
		else $error("hardware reset ended early");
	por_enter_a: assert property (!power_up_reset_n [*4] |-> hw_reset_active)
		else $error("hardware reset not entered");
	// pin rates: no sclk half over two cycles, no wake high half over nine
	sclk_rate_a: assert property (disable iff (!presetn || hw_reset_active)
		$stable(link_system_clock) |=> !$stable(link_system_clock)) else $error("sclk too slow");
	wake_half_a: assert property (link_wake_output [*8] |-> ##[1:2] !link_wake_output)
		else $error("wake high half too long");
	wake_rest_a: assert property (hw_reset_active ##1 hw_reset_active |-> !link_wake_output)
		else $error("wake active in reset");
	// live mode pins follow their inputs after the synchroniser
	speed_mode_a: assert property ((!hw_reset_active && $stable(speed_limit_strap)) [*5]
		|-> speed_limit_speed_limit_strap == speed_limit_strap) else $error("speed mode wrong");
	suspend_mode_a: assert property ((!hw_reset_active && $stable(suspend_resume_select)) [*5]
		|-> suspend_resume_en == suspend_resume_select) else $error("suspend mode wrong");
	couple_mode_a: assert property ((!hw_reset_active && $stable(coupling_select)) [*5]
		|-> dc_coupled_mode == coupling_select) else $error("coupling mode wrong");
	// strap seeds at the end of hardware reset
	port_load_a: assert property ($fell(hw_reset_active) |-> port_disabled == port_disable_straps)
		else $error("port disable not loaded");
	accel_load_a: assert property ($fell(hw_reset_active) |-> {accel_arb_en, fly_by_arb_en}
		== {2{accel_strap}}) else $error("accel not loaded");
	multi_load_a: assert property ($fell(hw_reset_active) |-> multi_speed_en == multi_speed_strap)
		else $error("multi speed not loaded");
	cover property ($fell(hw_reset_active));
	cover property ($rose(link_wake_output));
	cover property (speed_limit_speed_limit_strap && dc_coupled_mode);
endmodule
bind pscl_top pscl_top_props #(.POR_CYCLES(POR_CYCLES)) pscl_top_props_inst (.*);
`default_nettype wire

/* verif/pscl_link_model.sv */
// serial request source standing in for the link-layer controller.
// assumes the block's sclk as its clock; the line idles low when no frame is queued.
`timescale 1ns/100ps
`default_nettype none
module pscl_link_model (
	input wire logic sclk,
	output logic link_request_line
);
	logic [20:0] pend[$];
	logic [15:0] sh_ff;
	logic [4:0] cnt_ff = 5'h0;
	logic [20:0] nxt_frame;
	// queue a frame of len bits, msb first, start bit included
	task send(input logic [4:0] len, input logic [15:0] bits);
		pend.push_back({len, bits});
	endtask
	function automatic logic busy();
		return cnt_ff != 5'h0 || pend.size() != 0;
	endfunction
	initial link_request_line = 1'b0;
	// one bit per sclk rise; frames go back to back with no idle tick
	always @(posedge sclk) begin
		if (cnt_ff != 5'h0) begin
			link_request_line <= sh_ff[15];
			sh_ff <= sh_ff << 1;
			cnt_ff <= cnt_ff - 5'h1;
		end else if (pend.size() != 0) begin
			nxt_frame = pend.pop_front();
			link_request_line <= nxt_frame[15];
			sh_ff <= nxt_frame[15:0] << 1;
			cnt_ff <= nxt_frame[20:16] - 5'h1;
		end else begin
			link_request_line <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_pscl_top.sv */
// self-checking bench for the strap, reset and link-pin block.
// assumes the bound checker and the link model; por count cut to 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_pscl_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic power_up_reset_n = 1'b1;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [10:0] st = 11'h0;
	logic [34:0] q[$];
	logic pw, ps;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 32'h3b8909a0;
	int rw, hw, rs;
	wire [31:0] prdata;
	wire [7:0] link_read_data;
	wire [2:0] power_class_straps, bus_request_type;
	wire [1:0] port_disable_straps, port_disabled;
	wire pready, pslverr, link_request_line, link_system_clock, link_wake_output;
	wire hw_reset_active, speed_limit_speed_limit_strap, suspend_resume_en, dc_coupled_mode;
	wire accel_arb_en, fly_by_arb_en, multi_speed_en, link_read_valid, bus_request_valid;
	wire manager_capable_strap, speed_limit_strap, suspend_resume_select;
	wire accel_strap, multi_speed_strap, coupling_select;
	// all straps from one vector so expectations index it directly
	assign {coupling_select, multi_speed_strap, accel_strap, port_disable_straps,
		suspend_resume_select, speed_limit_strap, manager_capable_strap, power_class_straps} = st;
	pscl_top #(.POR_CYCLES(20)) pscl_top_inst (.*);
	pscl_link_model link_inst (.sclk(link_system_clock), .link_request_line(link_request_line));
	always #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [34:0] s, input logic [34:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task take(input logic [34:0] s);
		if (q.size() == 0)
			chk("unexpected", 1'b1, 1'b0);
		else
			chk("answer", s, q.pop_front());
	endtask
	// one apb transfer; request held until pready, answer queued first
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
		q.push_back({w, 1'b0, e});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask
	task wr(input logic [31:0] a, input logic [7:0] d, input logic err);
		apb(1'b1, a, {24'h0, d}, {err, 32'h0});
	endtask
	////////////////////////////////////////////////////////////////////////
	// every answer at the ports is matched to the oldest expectation
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready === 1'b1)
			take({pwrite, 1'b0, pslverr, pwrite ? 32'h0 : prdata}); // writes leave prdata
		if (link_read_valid === 1'b1)
			take({2'b01, 25'h0, link_read_data});
		if (bus_request_valid === 1'b1)
			take({2'b11, 30'h0, bus_request_type});
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	// new straps under a power-up pulse, then every seeded place is read
	task straps(input logic [10:0] v);
		logic [7:0] m;
		@(posedge pclk);
		power_up_reset_n <= 1'b0;
		st <= v;
		repeat (4) @(posedge pclk);
		power_up_reset_n <= 1'b1;
		@(posedge pclk);
		while (hw_reset_active !== 1'b0) @(posedge pclk);
		m = {speed_limit_speed_limit_strap, suspend_resume_en, dc_coupled_mode, port_disabled,
			accel_arb_en, fly_by_arb_en, multi_speed_en};
		chk("modes", m, {v[4], v[5], v[10], v[7:6], v[8], v[8], v[9]});
		rd(32'h0C, {25'h0, v[4] ? 8'h21 : 8'h41});
		rd(32'h10, {25'h0, 1'b1, v[3], 3'b001, v[0], v[1], v[2]});
		rd(32'h14, {31'h1, v[8], v[9]});
		rd(32'h20, {32'h0, v[6]});
		wr(32'h1C, 8'h01, 1'b0);
		rd(32'h20, {32'h0, v[7]});
		wr(32'h1C, 8'h00, 1'b0);
		rd(32'h44, {30'h0, v[10], v[5], 1'b0});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			straps(i == 0 ? 11'h000 : i == 1 ? 11'h7FF : 11'($random(seed)));
		// fixed, read-only and refused places
		rd(32'h00, 33'h0);
		rd(32'h04, 33'h3F);
		wr(32'h08, 8'h55, 1'b0);
		rd(32'h08, 33'hE2);
		rd(32'h18, 33'h0);
		rd(32'h60, {1'b1, 32'h0});
		rd(32'h05, {1'b1, 32'h0});
		wr(32'h80, 8'hFF, 1'b1);
		// software overrides hold against strap changes until the next reset
		wr(32'h10, 8'h00, 1'b0);
		wr(32'h14, 8'h03, 1'b0);
		rd(32'h14, 33'h07);
		chk("accel_on", {accel_arb_en, fly_by_arb_en, multi_speed_en}, 3'h7);
		wr(32'h14, 8'h04, 1'b0);
		rd(32'h14, 33'h00);
		chk("accel_off", {accel_arb_en, fly_by_arb_en, multi_speed_en}, 3'h0);
		st <= ~st;
		repeat (8) @(posedge pclk);
		rd(32'h10, 33'h08);
		straps(st);
		// serial requests back to back: write, reads, every type code
		link_inst.send(5'd16, {8'hE1, 8'h15});
		link_inst.send(5'd8, {8'hD1, 8'h00});
		q.push_back({2'b01, 25'h0, 8'h15});
		link_inst.send(5'd8, {8'hD2, 8'h00});
		q.push_back({2'b01, 25'h0, 8'hE2});
		for (int t = 0; t < 8; t++) begin
			if (t == 5 || t == 6)
				continue;
			link_inst.send(5'd4, {1'b1, 3'(t), 12'h0});
			if (t >= 1 && t <= 3)
				q.push_back({2'b11, 30'h0, 3'(t)});
		end
		while (link_inst.busy() || q.size() != 0) @(posedge pclk);
		rd(32'h04, 33'h15);
		// wake and sclk rates over a 1000-cycle window
		wr(32'h40, 8'h01, 1'b0);
		{rw, hw, rs, pw, ps} = '0;
		repeat (1000) begin
			@(posedge pclk);
			rw += int'(link_wake_output && !pw);
			hw += int'(link_wake_output);
			rs += int'(link_system_clock && !ps);
			pw = link_wake_output;
			ps = link_system_clock;
		end
		chk("wake_rate", rw inside {[60:63]}, 1'b1);
		chk("wake_duty", hw inside {[488:512]}, 1'b1);
		chk("sclk_rate", rs inside {[489:494]}, 1'b1);
		wr(32'h40, 8'h00, 1'b0);
		@(posedge pclk);
		hw = 0;
		repeat (200) @(posedge pclk) hw += int'(link_wake_output);
		chk("wake_idle", hw, 0);
		chk("leftover", q.size(), 0);
		complete_run();
	end
endmodule
`default_nettype wire
